// ==== hw/pib_ahb_port.sv ====
/*
 * AHB-Lite slave front end: takes address phases, hands reads out in
 * the address phase and writes out in the following data phase.
 * Assumes: single slave, zero wait states, word transfers.
 */
`timescale 1ns/100ps
module pib_ahb_port
   import pib_pkg::*;
(
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Bus side
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic         hready,
   output logic              hreadyout,
   output logic              hresp,
   // Register side
   output pib_bus_req_t      rd_req,
   output pib_bus_req_t      wr_req
);

   pib_bus_req_t wr_req_q;
   logic         hreadyout_q;
   logic         hresp_q;
   wire          take_w = hsel & htrans[1] & hready;
   wire          hit_w  = (haddr[31:ADDR_W] == '0);

   // Read served in the address phase
   assign rd_req    = '{hit: hit_w, rd: take_w & ~hwrite, wr: 1'b0,
                        addr: haddr[ADDR_W-1:0]};
   assign wr_req    = wr_req_q;
   assign hreadyout = hreadyout_q;
   assign hresp     = hresp_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_req_q    <= '0;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end else begin
         wr_req_q    <= '{hit: hit_w, rd: 1'b0, wr: take_w & hwrite,
                          addr: haddr[ADDR_W-1:0]};
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end
   end

endmodule : pib_ahb_port

// ==== hw/pib_pkg.sv ====
/*
 * Constants, carrier types and helpers of the peripheral interrupt
 * flag and enable bank.
 * Assumes: one system clock, AHB-Lite word access to the registers.
 */
package pib_pkg;

   ////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam int unsigned ADDR_W             = 8;
   localparam logic [7:0]  OFS_FLAGS_TWO      = 8'h00;
   localparam logic [7:0]  OFS_ENABLE_ONE     = 8'h04;
   localparam logic [7:0]  OFS_ENABLE_TWO     = 8'h08;
   localparam logic [7:0]  OFS_FLAGS_ONE_VIEW = 8'h0C;
   localparam logic [7:0]  OFS_GROUP_CTRL     = 8'h10;
   localparam logic [7:0]  OFS_IRQ_STATUS     = 8'h14;
   localparam logic [7:0]  OFS_IRQ_MASK       = 8'h18;

   ////////////////////////////////////////////////////////////////////
   // Field positions, second flag and second enable register
   localparam int BIT_OSC_FAIL  = 7;
   localparam int BIT_COMP_ONE  = 6;
   localparam int BIT_COMP_TWO  = 5;
   localparam int BIT_NVM_WRITE = 4;
   localparam int BIT_BUS_COLL  = 3;
   localparam int BIT_TIMER_THREE_OVF  = 1;

   // Field positions, first enable register
   localparam int BIT_CONV_DONE  = 6;
   localparam int BIT_SER_RX     = 5;
   localparam int BIT_SER_TX     = 4;
   localparam int BIT_SYNC_PORT  = 3;
   localparam int BIT_CAPCOMP    = 2;
   localparam int BIT_TIMER_TWO_MATCH = 1;
   localparam int BIT_TIMER_ONE_OVF   = 0;

   // Field positions, group control register
   localparam int BIT_GROUP_EN  = 0;
   localparam int BIT_PRIO_MODE = 1;

   ////////////////////////////////////////////////////////////////////
   // Implemented bits and reset values
   localparam logic [7:0] IMPL_ONE     = 8'h7F;
   localparam logic [7:0] IMPL_TWO     = 8'hFA;
   localparam logic [7:0] IMPL_CTRL    = 8'h03;
   localparam logic [7:0] RST_FLAGS    = 8'h00;
   localparam logic [7:0] RST_ENABLE   = 8'h00;
   localparam logic [7:0] RST_CTRL     = 8'h00;
   localparam logic [7:0] RST_MASK     = 8'h00;
   localparam logic [7:0] ALL_ONES     = 8'hFF;
   localparam logic [7:0] ALL_ZEROS    = 8'h00;

   ////////////////////////////////////////////////////////////////////
   // Bus encodings
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] HRDATA_RST    = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////
   // Carrier types
   typedef struct packed {
      logic              hit;
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
   } pib_bus_req_t;

   typedef struct packed {
      logic osc_fail;
      logic comp_one_out;
      logic comp_two_out;
      logic nvm_write_done;
      logic bus_collision;
      logic timer_three_ovf;
   } pib_events_t;

   ////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [7:0] pib_gate(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic [7:0] m);
      return a & b & m;
   endfunction : pib_gate

   function automatic logic pib_is(input pib_bus_req_t r,
                                   input logic [7:0]   ofs);
      return r.hit && (r.addr == ofs);
   endfunction : pib_is

endpackage : pib_pkg

// ==== hw/pib_sticky_bank.sv ====
/*
 * Bank of sticky flags: hardware set, software write or clear on read.
 * A set in the cycle of a write or a clear wins.
 * Assumes: set pulses synchronous to hclk.
 */
`timescale 1ns/100ps
module pib_sticky_bank #(
   parameter logic [7:0] IMPL  = 8'hFF,
   parameter logic [7:0] RST   = 8'h00
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Control
   input  wire logic [7:0]  set,
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_data,
   input  wire logic        clr_all,
   // State
   output logic      [7:0]  flags_d,
   output logic      [7:0]  flags_q
);

   wire [7:0] base_w = wr_en ? wr_data : flags_q;
   wire [7:0] kept_w = clr_all ? 8'h00 : base_w;

   assign flags_d = (kept_w | set) & IMPL;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_q <= RST;
      end else begin
         flags_q <= flags_d;
      end
   end

endmodule : pib_sticky_bank

// ==== hw/pib_top.sv ====
/*
 * Peripheral interrupt flag and enable bank with AHB-Lite registers,
 * gated per-source requests, group request and a status interrupt.
 * Assumes: peripherals give one-cycle event pulses and level flags,
 * all synchronous to hclk; hready is this slave's own hreadyout.
 */
// How it works
// - Comparator two output change sets its flag; stays until written zero.
// - Nonvolatile write completion sets its flag; software clears it.
// - Serial bus collision sets its flag; held until written zero.
// - Unimplemented flag and enable bits ignore writes, read zero.
// - Converter enable gates the converter-done request.
// - Serial receive enable gates the receive-full request.
// - Serial transmit enable gates the transmit-empty request.
// - Sync port enable gates its transfer-complete request.
// - Capture/compare enable gates its capture or match request.
// - Timer two match enable gates the period-match request.
// - Timer one overflow enable gates its overflow request.
// - Second enable register: one enable per second-group source.
`timescale 1ns/100ps
module pib_top
   import pib_pkg::*;
(
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // AHB-Lite slave
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic      [31:0]  hrdata,
   output logic              hreadyout,
   output logic              hresp,
   // Peripheral sources
   input  wire logic [7:0]   flags_one_in,
   input  pib_events_t       periph_evt,
   // Requests
   output logic      [7:0]   req_one,
   output logic      [7:0]   req_two,
   output logic              periph_req,
   output logic              irq
);

   ////////////////////////////////////////////////////////////////////
   // Bus front end
   pib_bus_req_t rd_req;
   pib_bus_req_t wr_req;

   pib_ahb_port u_port (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .rd_req    (rd_req),
      .wr_req    (wr_req)
   );

   wire [7:0] wdata_w      = hwdata[7:0];
   wire       wr_flags_w   = wr_req.wr & pib_is(wr_req, OFS_FLAGS_TWO);
   wire       wr_en_one_w  = wr_req.wr & pib_is(wr_req, OFS_ENABLE_ONE);
   wire       wr_en_two_w  = wr_req.wr & pib_is(wr_req, OFS_ENABLE_TWO);
   wire       wr_ctrl_w    = wr_req.wr & pib_is(wr_req, OFS_GROUP_CTRL);
   wire       wr_mask_w    = wr_req.wr & pib_is(wr_req, OFS_IRQ_MASK);
   wire       rd_status_w  = rd_req.rd & pib_is(rd_req, OFS_IRQ_STATUS);

   ////////////////////////////////////////////////////////////////////
   // Event detection
   logic       comp_one_prev_q;
   logic       comp_two_prev_q;
   logic       comp_seen_q;
   wire        comp_one_chg_w = comp_seen_q &
                  (periph_evt.comp_one_out ^ comp_one_prev_q);
   wire        comp_two_chg_w = comp_seen_q &
                  (periph_evt.comp_two_out ^ comp_two_prev_q);
   logic [7:0] set_two_w;

   always_comb begin
      set_two_w                = 8'h00;
      set_two_w[BIT_OSC_FAIL]  = periph_evt.osc_fail;
      set_two_w[BIT_COMP_ONE]  = comp_one_chg_w;
      set_two_w[BIT_COMP_TWO]  = comp_two_chg_w;
      set_two_w[BIT_NVM_WRITE] = periph_evt.nvm_write_done;
      set_two_w[BIT_BUS_COLL]  = periph_evt.bus_collision;
      set_two_w[BIT_TIMER_THREE_OVF]  = periph_evt.timer_three_ovf;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         comp_one_prev_q <= 1'b0;
         comp_two_prev_q <= 1'b0;
         comp_seen_q     <= 1'b0;
      end else begin
         comp_one_prev_q <= periph_evt.comp_one_out;
         comp_two_prev_q <= periph_evt.comp_two_out;
         comp_seen_q     <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Second flag register and event status
   logic [7:0] flags_two_d;
   logic [7:0] flags_two_q;
   logic [7:0] status_d;
   logic [7:0] status_q;

   // Sticky, set wins, unimplemented bits held at zero
   pib_sticky_bank #(
      .IMPL (IMPL_TWO),
      .RST  (RST_FLAGS)
   ) u_flags_two (
      .hclk    (hclk),
      .hresetn (hresetn),
      .set     (set_two_w),
      .wr_en   (wr_flags_w),
      .wr_data (wdata_w),
      .clr_all (1'b0),
      .flags_d (flags_two_d),
      .flags_q (flags_two_q)
   );

   // Cleared by a read of the status register
   pib_sticky_bank #(
      .IMPL (IMPL_TWO),
      .RST  (RST_FLAGS)
   ) u_status (
      .hclk    (hclk),
      .hresetn (hresetn),
      .set     (set_two_w),
      .wr_en   (1'b0),
      .wr_data (ALL_ZEROS),
      .clr_all (rd_status_w),
      .flags_d (status_d),
      .flags_q (status_q)
   );

   ////////////////////////////////////////////////////////////////////
   // Enable, group control and mask registers
   logic [7:0] en_one_q;
   logic [7:0] en_two_q;
   logic [7:0] ctrl_q;
   logic [7:0] mask_q;
   wire  [7:0] en_one_d = wr_en_one_w ? (wdata_w & IMPL_ONE) : en_one_q;
   wire  [7:0] en_two_d = wr_en_two_w ? (wdata_w & IMPL_TWO) : en_two_q;
   wire  [7:0] ctrl_d   = wr_ctrl_w ? (wdata_w & IMPL_CTRL) : ctrl_q;
   wire  [7:0] mask_d   = wr_mask_w ? (wdata_w & IMPL_TWO) : mask_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_one_q <= RST_ENABLE;
         en_two_q <= RST_ENABLE;
         ctrl_q   <= RST_CTRL;
         mask_q   <= RST_MASK;
      end else begin
         en_one_q <= en_one_d;
         en_two_q <= en_two_d;
         ctrl_q   <= ctrl_d;
         mask_q   <= mask_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Request gating
   wire [7:0] flags_one_w = flags_one_in & IMPL_ONE;
   wire [7:0] req_one_w   = pib_gate(flags_one_w, en_one_q, IMPL_ONE);
   wire [7:0] req_two_w   = pib_gate(flags_two_q, en_two_q, IMPL_TWO);
   wire       group_ok_w  = ctrl_q[BIT_GROUP_EN] | ctrl_q[BIT_PRIO_MODE];
   wire       periph_w    = group_ok_w & (|{req_one_w, req_two_w});
   wire       irq_w       = |(status_q & mask_q);

   logic [7:0] req_one_q;
   logic [7:0] req_two_q;
   logic       periph_req_q;
   logic       irq_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_one_q    <= 8'h00;
         req_two_q    <= 8'h00;
         periph_req_q <= 1'b0;
         irq_q        <= 1'b0;
      end else begin
         req_one_q    <= req_one_w;
         req_two_q    <= req_two_w;
         periph_req_q <= periph_w;
         irq_q        <= irq_w;
      end
   end

   assign req_one    = req_one_q;
   assign req_two    = req_two_q;
   assign periph_req = periph_req_q;
   assign irq        = irq_q;

   ////////////////////////////////////////////////////////////////////
   // Read data, bypassing a write in its data phase
   logic [7:0]  rd_byte_w;
   logic [31:0] hrdata_q;

   always_comb begin
      rd_byte_w = 8'h00;
      if (rd_req.hit) begin
         unique case (rd_req.addr)
            OFS_FLAGS_TWO:      rd_byte_w = flags_two_d;
            OFS_ENABLE_ONE:     rd_byte_w = en_one_d;
            OFS_ENABLE_TWO:     rd_byte_w = en_two_d;
            OFS_FLAGS_ONE_VIEW: rd_byte_w = flags_one_w;
            OFS_GROUP_CTRL:     rd_byte_w = ctrl_d;
            OFS_IRQ_STATUS:     rd_byte_w = status_q;
            OFS_IRQ_MASK:       rd_byte_w = mask_d;
            default:            rd_byte_w = 8'h00;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= HRDATA_RST;
      end else if (rd_req.rd) begin
         hrdata_q <= {24'h00_0000, rd_byte_w};
      end
   end

   assign hrdata = hrdata_q;

   ////////////////////////////////////////////////////////////////////
   // Checks
   logic rst_seen_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_seen_q <= 1'b0;
      end else begin
         rst_seen_q <= 1'b1;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chk_comp_two_flag: assert property (
      comp_two_chg_w |=> flags_two_q[BIT_COMP_TWO])
      else $error("comparator two change did not set its flag");

   chk_nvm_done_flag: assert property (
      periph_evt.nvm_write_done |=> flags_two_q[BIT_NVM_WRITE])
      else $error("nvm write done did not set its flag");

   chk_bus_coll_hold: assert property (
      (flags_two_q[BIT_BUS_COLL] && !wr_flags_w)
      |=> flags_two_q[BIT_BUS_COLL])
      else $error("bus collision flag dropped without a write");

   chk_unimpl_zero: assert property (
      ((flags_two_q & ~IMPL_TWO) == 8'h00) &&
      ((en_one_q & ~IMPL_ONE) == 8'h00) &&
      ((en_two_q & ~IMPL_TWO) == 8'h00) && (hrdata[31:8] == '0))
      else $error("unimplemented bit reads nonzero");

   chk_group_gate: assert property (
      periph_req |-> $past(ctrl_q[BIT_GROUP_EN] | ctrl_q[BIT_PRIO_MODE]))
      else $error("group request without group enable");

   chk_req_one_gate: assert property (
      ##1 req_one == $past(flags_one_in & en_one_q & IMPL_ONE))
      else $error("first group request not flag and enable");

   chk_req_two_gate: assert property (
      ##1 req_two == $past(flags_two_q & en_two_q))
      else $error("second group request not flag and enable");

   chk_timer_three_flag: assert property (
      periph_evt.timer_three_ovf ##1 !wr_flags_w
      |-> flags_two_q[BIT_TIMER_THREE_OVF] ##1 flags_two_q[BIT_TIMER_THREE_OVF])
      else $error("timer three overflow flag not held");

   chk_flag_no_enable: assert property (
      (periph_evt.bus_collision && !en_two_q[BIT_BUS_COLL])
      |=> flags_two_q[BIT_BUS_COLL])
      else $error("flag not set while its enable is zero");

   chk_enable_reset: assert property (
      !rst_seen_q |-> (en_one_q == 8'h00) && (en_two_q == 8'h00))
      else $error("enable bits not clear after reset");

   chk_irq_level: assert property (
      ##1 irq == $past(|(status_q & mask_q)))
      else $error("interrupt output does not follow status and mask");

   cov_enable_write: cover property (wr_en_one_w ##1 en_one_q != 8'h00);
   cov_comp_two_req: cover property (comp_two_chg_w ##2 req_two[5]);
   cov_status_clear: cover property (rd_status_w && status_q != 8'h00);
   cov_irq_rise:     cover property ($rose(irq));

endmodule : pib_top

// ==== sim/peripheral_irq_enable_flag_bank_bench.sv ====
/*
 * Self-checking bench of the peripheral interrupt flag and enable bank.
 * Assumes: pib_pkg, pib_top and pib_periph_model compiled before it.
 */
`timescale 1ns/100ps
module peripheral_irq_enable_flag_bank_bench
   import pib_pkg::*;
;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic        hwrite;
   logic        hreadyout;
   logic        hresp;
   logic        periph_req;
   logic        irq;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [7:0]  lvl_one;
   logic [7:0]  flags_one_in;
   logic [7:0]  req_one;
   logic [7:0]  req_two;
   logic [7:0]  b;
   logic [31:0] e;
   logic [31:0] g;
   logic [5:0]  fire;
   pib_events_t periph_evt;
   int          errors = 0;
   int          check_count = 0;
   int          cycles = 0;
   // Rows: enable_one, flags_one_in, expected req_one
   logic [23:0] rows [11] = '{24'h7FFF7F, 24'h40FF40, 24'h20FF20,
      24'h10FF10, 24'h08FF08, 24'h04FF04, 24'h02FF02, 24'h01FF01,
      24'hFF0000, 24'h007F00, 24'h7F2A2A};
   int          evt_bit [6] = '{BIT_TIMER_THREE_OVF, BIT_BUS_COLL, BIT_NVM_WRITE,
      BIT_COMP_TWO, BIT_COMP_ONE, BIT_OSC_FAIL};

   pib_top u_pib_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .flags_one_in(flags_one_in),
      .periph_evt(periph_evt), .req_one(req_one), .req_two(req_two),
      .periph_req(periph_req), .irq(irq));

   pib_periph_model u_pib_periph_model (.hclk(hclk), .hresetn(hresetn),
      .fire(fire), .lvl_one(lvl_one), .periph_evt(periph_evt),
      .flags_one_in(flags_one_in));

   ////////////////////////////////////////////////////////////////////
   // Clock and timeout
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask : tick

   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask : wr

   task automatic rd_chk(input string n, input logic [7:0] a,
                         input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      chk(n, e, q);
   endtask : rd_chk

   task automatic pulse(input logic [5:0] f);
      fire <= f;
      tick(1);
      fire <= 6'h00;
      tick(3);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hresetn = 1'b0;
      hsize   = 3'h2;
      lvl_one = 8'h00;
      fire    = 6'h00;
      tick(10);
      hresetn <= 1'b1;
      tick(1);
      chk("irq", 32'h0, {31'h0, irq});
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
      rd_chk("enable_one", OFS_ENABLE_ONE, 32'h0);
      rd_chk("enable_two", OFS_ENABLE_TWO, 32'h0);
      rd_chk("flags_two", OFS_FLAGS_TWO, 32'h0);
      foreach (rows[i]) begin
         wr(OFS_ENABLE_ONE, {24'h0, rows[i][23:16]});
         lvl_one <= rows[i][15:8];
         tick(2);
         e = {24'h0, rows[i][7:0]};
         g = {24'h0, req_one};
         chk("req_one", e, g);
         e = {24'h0, rows[i][23:16] & IMPL_ONE};
         rd_chk("enable_one", OFS_ENABLE_ONE, e);
         e = {24'h0, rows[i][15:8] & IMPL_ONE};
         rd_chk("flags_view", OFS_FLAGS_ONE_VIEW, e);
      end
      // Group gating with first-group requests standing
      for (int c = 0; c < 4; c++) begin
         wr(OFS_GROUP_CTRL, 32'(c));
         tick(2);
         chk("periph_req", {31'h0, c != 0}, {31'h0, periph_req});
      end
      lvl_one <= 8'h00;
      tick(3);
      chk("periph_req idle", 32'h0, {31'h0, periph_req});
      wr(OFS_GROUP_CTRL, 32'h1);
      // Each second-group source: flag set, gated, cleared by write
      for (int k = 0; k < 6; k++) begin
         b = 8'h01 << evt_bit[k];
         e = {24'h0, b};
         wr(OFS_ENABLE_TWO, 32'h0);
         pulse(6'h01 << k);
         chk("req_two off", 32'h0, {24'h0, req_two});
         rd_chk("flags_two", OFS_FLAGS_TWO, e);
         wr(OFS_ENABLE_TWO, e);
         tick(2);
         chk("req_two on", e, {24'h0, req_two});
         chk("periph_req", 32'h1, {31'h0, periph_req});
         wr(OFS_FLAGS_TWO, 32'h0);
         tick(2);
         chk("req_two clr", 32'h0, {24'h0, req_two});
      end
      // Status sticky, read clears, mask gates irq
      rd_chk("status", OFS_IRQ_STATUS, {24'h0, IMPL_TWO});
      rd_chk("status clr", OFS_IRQ_STATUS, 32'h0);
      wr(OFS_IRQ_MASK, 32'h08);
      pulse(6'h02);
      chk("irq on", 32'h1, {31'h0, irq});
      rd_chk("status", OFS_IRQ_STATUS, 32'h08);
      tick(2);
      chk("irq off", 32'h0, {31'h0, irq});
      wr(OFS_IRQ_MASK, 32'h00);
      pulse(6'h02);
      chk("irq masked", 32'h0, {31'h0, irq});
      // Unimplemented bits and unmapped place
      wr(OFS_FLAGS_TWO, 32'hFF);
      rd_chk("flags_two", OFS_FLAGS_TWO, {24'h0, IMPL_TWO});
      wr(OFS_ENABLE_TWO, 32'hFF);
      rd_chk("enable_two", OFS_ENABLE_TWO, {24'h0, IMPL_TWO});
      wr(8'h40, 32'hFF);
      rd_chk("unmapped", 8'h40, 32'h0);
      chk("hresp", 32'h0, {31'h0, hresp});
      // Collision in the data phase of a flag write: set and write merge
      fork
         wr(OFS_FLAGS_TWO, 32'h02);
         begin
            tick(1);
            fire <= 6'h02;
            tick(1);
            fire <= 6'h00;
         end
      join
      rd_chk("flags race", OFS_FLAGS_TWO, 32'h0A);
      // Collision at the edge that takes a status read: set kept
      fork
         rd_chk("status race", OFS_IRQ_STATUS, 32'h08);
         begin
            fire <= 6'h02;
            tick(1);
            fire <= 6'h00;
         end
      join
      rd_chk("status kept", OFS_IRQ_STATUS, 32'h08);
      // Second reset in mid-run
      hresetn <= 1'b0;
      tick(2);
      hresetn <= 1'b1;
      tick(1);
      chk("req_two rst", 32'h0, {24'h0, req_two});
      chk("periph_req rst", 32'h0, {31'h0, periph_req});
      rd_chk("enable_one", OFS_ENABLE_ONE, 32'h0);
      rd_chk("enable_two", OFS_ENABLE_TWO, 32'h0);
      summarize();
   end

endmodule : peripheral_irq_enable_flag_bank_bench

// ==== sim/pib_periph_model.sv ====
/*
 * Behavioural peripheral sources: event pulses, comparator levels and
 * first-group level flags, all driven from bench commands.
 * Assumes: commands change just after a rising hclk edge.
 */
`timescale 1ns/100ps
module pib_periph_model
   import pib_pkg::*;
(
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // Commands, bit order of pib_events_t
   input  wire logic [5:0]  fire,
   input  wire logic [7:0]  lvl_one,
   // Sources
   output pib_events_t      periph_evt,
   output logic      [7:0]  flags_one_in
);

   ////////////////////////////////////////////////////////////////////
   // Comparator outputs toggle on command
   logic c1_q;
   logic c2_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         c1_q <= 1'b0;
         c2_q <= 1'b0;
      end else begin
         c1_q <= c1_q ^ fire[4];
         c2_q <= c2_q ^ fire[3];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Source outputs
   assign periph_evt   = {fire[5], c1_q, c2_q, fire[2], fire[1], fire[0]};
   assign flags_one_in = lvl_one;

endmodule : pib_periph_model
